//--- src/eeprom_link_defs.svh
// Constants of the module-info EEPROM two-wire slave
`ifndef EEPROM_LINK_DEFS_SVH
`define EEPROM_LINK_DEFS_SVH
`define DEVTYPE_MEM 4'ha
`define DEVTYPE_PROT 4'h6
`define BYTE_BITS 4'h8
`define ACK_DONE 4'h9
`define PROT_LOCK_BIT 0
`define PROT_RESET 8'h00
`define PAGE_BYTES 16
`define MEM_DEPTH 256
`define FIFO_WIDTH 8
`endif

//--- src/eeprom_link_pkg.sv
// Types shared by the module-info EEPROM two-wire slave
package eeprom_link_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_s;
  typedef struct packed {
    logic wc;
    logic [2:0] dev_addr;
  } strap_s;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEV    = 3'b001,
    ST_WADDR  = 3'b010,
    ST_WDATA  = 3'b011,
    ST_READ   = 3'b100,
    ST_WAIT   = 3'b101,
    ST_COMMIT = 3'b110
  } link_state_e;
endpackage

//--- src/eeprom_page_fifo.sv
// Page buffer FIFO between the receive path and the array write
`timescale 1ns/1ps
module eeprom_page_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  input wire logic out_ready_in,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
    $error("eeprom_page_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = wr_ptr != rd_ptr;
  assign out_data_out = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= '0;
    end else if (in_valid_in && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_ptr <= '0;
    end else if (out_ready_in && out_valid_out) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage carries no reset; only entries behind wr_ptr are ever read
  always_ff @(posedge clk_in) begin
    if (in_valid_in && !full) begin
      store[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
endmodule // eeprom_page_fifo

//--- src/module_info_eeprom.sv
// Two-wire slave of the module-info EEPROM with array and page buffer
`timescale 1ns/1ps
`include "eeprom_link_defs.svh"
module module_info_eeprom #(
  parameter int MEM_BYTES = `MEM_DEPTH,
  parameter int PAGE = `PAGE_BYTES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic dev_addr_pin_0_in,
  input wire logic dev_addr_pin_1_in,
  input wire logic dev_addr_pin_2_in,
  input wire logic write_control_pin_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic standby_out,
  output logic busy_out
);
  localparam int AW = $clog2(MEM_BYTES);

  if (MEM_BYTES < 2 || MEM_BYTES > `MEM_DEPTH ||
      (1 << AW) != MEM_BYTES || PAGE < 2) begin : g_bad_cfg
    $error("module_info_eeprom: unsupported MEM_BYTES or PAGE");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  eeprom_link_pkg::bus_s bus_meta;
  eeprom_link_pkg::bus_s bus_sync;
  eeprom_link_pkg::bus_s bus_prev;
  eeprom_link_pkg::strap_s strap_meta;
  eeprom_link_pkg::strap_s strap_sync;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_meta <= '1;
      bus_sync <= '1;
      bus_prev <= '1;
    end else begin
      bus_meta <= '{scl: scl_in, sda: sda_in};
      bus_sync <= bus_meta;
      bus_prev <= bus_sync;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      strap_meta <= '{wc: write_control_pin_in,
                      dev_addr: {dev_addr_pin_2_in, dev_addr_pin_1_in,
                                 dev_addr_pin_0_in}};
      strap_sync <= strap_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus events

  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;

  assign scl_s = bus_sync.scl;
  assign sda_s = bus_sync.sda;
  assign rise = scl_s && !bus_prev.scl;
  assign fall = !scl_s && bus_prev.scl;
  // Data edges only count while SCL stayed high across both samples
  assign start_det = scl_s && bus_prev.scl && bus_prev.sda && !sda_s;
  assign stop_det = scl_s && bus_prev.scl && !bus_prev.sda && sda_s;

  function automatic logic at_slot(input logic edge_hit,
                                   input logic [3:0] count,
                                   input logic [3:0] slot);
    return edge_hit && (count == slot);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State and byte framing

  eeprom_link_pkg::link_state_e state;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic rw;
  logic is_prot;
  logic nack;
  logic [AW-1:0] ptr;
  logic [AW-1:0] wptr;
  logic [7:0] prot_reg;
  logic [7:0] mem [MEM_BYTES];
  logic dev_match;
  logic [7:0] rd_byte;
  logic push;
  logic fifo_ready;
  logic fifo_valid;
  logic pop;
  logic [7:0] fifo_data;
  logic in_write;

  // Select byte: type in [7:4], chip enables in [3:1], read flag in [0]
  assign dev_match = (sh[3:1] == strap_sync.dev_addr) &&
                     (sh[7:4] == `DEVTYPE_MEM ||
                      sh[7:4] == `DEVTYPE_PROT);
  assign rd_byte = is_prot ? prot_reg : mem[ptr];
  assign in_write = (state == eeprom_link_pkg::ST_WADDR) ||
                    (state == eeprom_link_pkg::ST_WDATA);
  // Bytes beyond a full page are acknowledged but dropped
  assign push = at_slot(fall, cnt, `ACK_DONE) && !strap_sync.wc &&
                (state == eeprom_link_pkg::ST_WDATA) && fifo_ready;
  assign pop = (state == eeprom_link_pkg::ST_COMMIT) && fifo_valid;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= eeprom_link_pkg::ST_IDLE;
    end else if (state == eeprom_link_pkg::ST_COMMIT) begin
      // Busy writing: the bus is not answered until the buffer drains
      if (!fifo_valid) begin
        state <= eeprom_link_pkg::ST_IDLE;
      end
    end else if (start_det) begin
      state <= eeprom_link_pkg::ST_DEV;
    end else if (stop_det) begin
      state <= (state == eeprom_link_pkg::ST_WDATA && fifo_valid) ?
               eeprom_link_pkg::ST_COMMIT : eeprom_link_pkg::ST_IDLE;
    end else if (fall) begin
      case (state)
        eeprom_link_pkg::ST_DEV: begin
          if (cnt == `BYTE_BITS && !dev_match) begin
            state <= eeprom_link_pkg::ST_IDLE;
          end else if (cnt == `ACK_DONE) begin
            state <= rw ? eeprom_link_pkg::ST_READ :
                     eeprom_link_pkg::ST_WADDR;
          end
        end
        eeprom_link_pkg::ST_WADDR: begin
          if (cnt == `ACK_DONE) begin
            state <= eeprom_link_pkg::ST_WDATA;
          end
        end
        eeprom_link_pkg::ST_READ: begin
          if (cnt == `ACK_DONE && nack) begin
            state <= eeprom_link_pkg::ST_WAIT;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= '0;
    end else if (start_det) begin
      cnt <= '0;
    end else if (rise && cnt != `ACK_DONE) begin
      cnt <= cnt + 4'h1;
    end else if (at_slot(fall, cnt, `ACK_DONE)) begin
      cnt <= '0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rw <= 1'b0;
      is_prot <= 1'b0;
    end else if (state == eeprom_link_pkg::ST_DEV &&
                 at_slot(fall, cnt, `BYTE_BITS)) begin
      rw <= sh[0];
      is_prot <= sh[7:4] == `DEVTYPE_PROT;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nack <= 1'b0;
    end else if (state == eeprom_link_pkg::ST_READ &&
                 at_slot(rise, cnt, `BYTE_BITS)) begin
      nack <= sda_s;
    end
  end

  // Receive shifts in MSB first; transmit shifts the next bit up to [7]
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh <= '0;
    end else if (rise && cnt < `BYTE_BITS) begin
      if (state == eeprom_link_pkg::ST_READ) begin
        sh <= {sh[6:0], 1'b0};
      end else begin
        sh <= {sh[6:0], sda_s};
      end
    end else if (at_slot(fall, cnt, `ACK_DONE) &&
                 ((state == eeprom_link_pkg::ST_DEV && rw) ||
                  (state == eeprom_link_pkg::ST_READ && !nack))) begin
      sh <= rd_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data line drive; drive is taken up only on SCL falls, start, stop and commit release it

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sda_oe_out <= 1'b0;
    end else if (start_det || stop_det ||
                 state == eeprom_link_pkg::ST_COMMIT) begin
      sda_oe_out <= 1'b0;
    end else if (fall) begin
      case (state)
        eeprom_link_pkg::ST_DEV: begin
          if (cnt == `BYTE_BITS) begin
            sda_oe_out <= dev_match;
          end else if (cnt == `ACK_DONE) begin
            sda_oe_out <= rw && !rd_byte[7];
          end
        end
        eeprom_link_pkg::ST_WADDR, eeprom_link_pkg::ST_WDATA: begin
          if (cnt == `BYTE_BITS) begin
            sda_oe_out <= 1'b1;
          end else if (cnt == `ACK_DONE) begin
            sda_oe_out <= 1'b0;
          end
        end
        eeprom_link_pkg::ST_READ: begin
          if (cnt < `BYTE_BITS) begin
            sda_oe_out <= !sh[7];
          end else if (cnt == `BYTE_BITS) begin
            sda_oe_out <= 1'b0;
          end else begin
            sda_oe_out <= !nack && !rd_byte[7];
          end
        end
        default: begin
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address pointers and array

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ptr <= '0;
    end else if (state == eeprom_link_pkg::ST_WADDR && !is_prot &&
                 at_slot(fall, cnt, `ACK_DONE)) begin
      ptr <= sh[AW-1:0];
    end else if (state == eeprom_link_pkg::ST_READ && !is_prot &&
                 at_slot(fall, cnt, `BYTE_BITS)) begin
      ptr <= ptr + 1'b1;
    end else if (push && !is_prot) begin
      ptr <= ptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wptr <= '0;
    end else if (state == eeprom_link_pkg::ST_WADDR &&
                 at_slot(fall, cnt, `ACK_DONE)) begin
      wptr <= sh[AW-1:0];
    end else if (pop) begin
      wptr <= wptr + 1'b1;
    end
  end

  // Lock bit in the protection register freezes the whole array
  always_ff @(posedge sys_clk_in) begin
    if (pop && !is_prot && !prot_reg[`PROT_LOCK_BIT]) begin
      mem[wptr] <= fifo_data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prot_reg <= `PROT_RESET;
    end else if (pop && is_prot) begin
      prot_reg <= fifo_data;
    end
  end

  // Whole page is held until stop; bytes of a write cut by a repeated start stay queued
  eeprom_page_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(PAGE)
  ) u_page_fifo (
    .clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(push),
    .in_data_in(sh),
    .in_ready_out(fifo_ready),
    .out_ready_in(pop),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Status outputs

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      standby_out <= 1'b1;
      busy_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      standby_out <= state == eeprom_link_pkg::ST_IDLE;
      busy_out <= state == eeprom_link_pkg::ST_COMMIT;
      sda_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  chk_drive_scl_low: assert property (
    $rose(sda_oe_out) |-> !scl_s)
    else $error("data line drive began while SCL high");

  chk_idle_ignore: assert property (
    (state == eeprom_link_pkg::ST_IDLE && !start_det) |=>
    (state == eeprom_link_pkg::ST_IDLE && !sda_oe_out))
    else $error("idle slave reacted without start");

  chk_stop_standby: assert property (
    (stop_det && state != eeprom_link_pkg::ST_WDATA &&
     state != eeprom_link_pkg::ST_COMMIT) |=>
    (state == eeprom_link_pkg::ST_IDLE) ##1 standby_out)
    else $error("stop did not lead to standby");

  chk_select_ack: assert property (
    (state == eeprom_link_pkg::ST_DEV && fall && cnt == `BYTE_BITS &&
     dev_match) |=> sda_oe_out)
    else $error("matching select byte not acknowledged");

  chk_select_miss: assert property (
    (state == eeprom_link_pkg::ST_DEV && fall && cnt == `BYTE_BITS &&
     !dev_match) |=> (state == eeprom_link_pkg::ST_IDLE && !sda_oe_out))
    else $error("foreign select byte was answered");

  chk_write_ack: assert property (
    (in_write && fall && cnt == `BYTE_BITS) |=> sda_oe_out)
    else $error("written byte not acknowledged");

  chk_read_release: assert property (
    (state == eeprom_link_pkg::ST_READ && !is_prot && fall &&
     cnt == `BYTE_BITS) |=>
    (!sda_oe_out && ptr == AW'($past(ptr) + 1'b1)))
    else $error("read byte end: no release or no pointer step");

  chk_nack_wait: assert property (
    (state == eeprom_link_pkg::ST_READ && fall && cnt == `ACK_DONE &&
     nack) |=> (state == eeprom_link_pkg::ST_WAIT && !sda_oe_out))
    else $error("missing acknowledge did not stop transmit");

  chk_read_next: assert property (
    (state == eeprom_link_pkg::ST_READ && fall && cnt == `ACK_DONE &&
     !nack && !start_det && !stop_det) |=>
    (state == eeprom_link_pkg::ST_READ && cnt == 4'h0))
    else $error("acknowledged read did not continue");

  chk_wc_block: assert property (
    (state == eeprom_link_pkg::ST_WDATA && fall && cnt == `ACK_DONE &&
     strap_sync.wc) |=> $stable(ptr))
    else $error("write accepted while write control high");
endmodule // module_info_eeprom

//--- dv/i2c_master_model.sv
// Behavioural two-wire bus master clocked by the link clock
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic lclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Clock stands high and data is released outside frames
  initial begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Data moves only in the clock low phase, sampled one link clock into the two-clock high phase
  task automatic bit_x(input logic drv, output logic smp);
    @(posedge lclk_in) scl_out <= 1'h0;
    @(posedge lclk_in) sda_low_out <= !drv;
    @(posedge lclk_in) scl_out <= 1'h1;
    @(posedge lclk_in) smp = sda_in;
  endtask
  // Also serves as repeated start: clock is dropped first to free the line
  task automatic start();
    @(posedge lclk_in) scl_out <= 1'h0;
    @(posedge lclk_in) sda_low_out <= 1'h0;
    @(posedge lclk_in) scl_out <= 1'h1;
    @(posedge lclk_in) sda_low_out <= 1'h1;
  endtask
  task automatic stop();
    @(posedge lclk_in) scl_out <= 1'h0;
    @(posedge lclk_in) sda_low_out <= 1'h1;
    @(posedge lclk_in) scl_out <= 1'h1;
    @(posedge lclk_in) sda_low_out <= 1'h0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'h1, s);
    ack = !s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'h1, s);
      b[i] = s;
    end
    bit_x(!ack, s);
  endtask
endmodule // i2c_master_model

//--- dv/module_info_eeprom_tb_top.sv
// Self-checking bench of the module-info EEPROM two-wire slave
`timescale 1ns/1ps
module module_info_eeprom_tb_top;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] SEL_W = {4'ha, STRAP, 1'h0};
  localparam logic [7:0] SEL_R = {4'ha, STRAP, 1'h1};
  typedef struct packed {
    logic [7:0] sel;
    logic ack;
  } row_s;
  logic sys_clk = 1'h0;
  logic lclk = 1'h0;
  logic arst_n = 1'h0;
  logic [2:0] pins = STRAP;
  logic wr_ctrl = 1'h0;
  logic scl;
  logic m_low;
  logic sda_out;
  logic sda_oe;
  logic standby;
  logic busy;
  logic a;
  logic [7:0] b;
  int num_errors = 0;
  int comparisons = 0;
  // Open-drain wire with pull-up
  wire sda = (sda_oe ? sda_out : 1'h1) & !m_low;
  // Mismatched straps and foreign type nibbles must be refused
  row_s rows [8] = '{
    '{SEL_W, 1'h1}, '{8'h6a, 1'h1}, '{8'ha8, 1'h0}, '{8'hae, 1'h0},
    '{8'ha2, 1'h0}, '{8'h5a, 1'h0}, '{8'hea, 1'h0}, '{8'h2a, 1'h0}};
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  module_info_eeprom uut (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .scl_in(scl), .sda_in(sda),
    .dev_addr_pin_0_in(pins[0]), .dev_addr_pin_1_in(pins[1]),
    .dev_addr_pin_2_in(pins[2]), .write_control_pin_in(wr_ctrl),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .standby_out(standby),
    .busy_out(busy));
  i2c_master_model master (
    .lclk_in(lclk), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input int i);
    return {i[3:0], ~i[3:0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded wait for the array commit to finish
  task automatic idle();
    for (int i = 0; i < 200 && !(busy === 1'h0 && standby === 1'h1); i++)
      @(posedge sys_clk);
    check("standby", {7'h0, standby}, 8'h01);
  endtask
  task automatic point(input logic [7:0] adr);
    master.start();
    master.send_byte(SEL_W, a);
    master.send_byte(adr, a);
    master.start();
    master.send_byte(SEL_R, a);
    check("read select ack", {7'h0, a}, 8'h01);
  endtask
  task automatic wr1(input logic [7:0] adr, d);
    master.start();
    master.send_byte(SEL_W, a);
    master.send_byte(adr, a);
    master.send_byte(d, a);
    check("data ack", {7'h0, a}, 8'h01);
    master.stop();
    idle();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Tests need about 34k system cycles; give up at 80k
  initial begin
    #400_000;
    num_errors++;
    results();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (8) @(posedge sys_clk);
    foreach (rows[i]) begin
      master.start();
      master.send_byte(rows[i].sel, a);
      check("select ack", {7'h0, a}, {7'h0, rows[i].ack});
      master.stop();
      idle();
    end
    $display("test select decode done");
    // Full page, then sequential read back from the page start at 8'h10
    master.start();
    master.send_byte(SEL_W, a);
    master.send_byte(8'h10, a);
    for (int i = 0; i < 16; i++) begin
      master.send_byte(pat(i), a);
      check("page ack", {7'h0, a}, 8'h01);
    end
    master.stop();
    idle();
    point(8'h10);
    for (int i = 0; i < 4; i++) begin
      master.recv_byte(i < 3, b);
      check("seq read", b, pat(i));
    end
    master.stop();
    $display("test page and sequential done");
    master.start();
    master.send_byte(SEL_R, a);
    master.recv_byte(1'h0, b);
    check("current read", b, pat(4));
    // After a refused byte the slave must leave the line alone
    master.recv_byte(1'h0, b);
    check("released", b, 8'hff);
    master.stop();
    $display("test current read and nack done");
    @(posedge sys_clk) wr_ctrl <= 1'h1;
    wr1(8'h12, 8'h00);
    @(posedge sys_clk) wr_ctrl <= 1'h0;
    point(8'h12);
    master.recv_byte(1'h0, b);
    check("blocked write", b, pat(2));
    master.stop();
    wr1(8'h15, 8'hc3);
    master.start();
    master.send_byte(SEL_R, a);
    master.recv_byte(1'h0, b);
    check("ptr after write", b, pat(6));
    master.stop();
    point(8'h15);
    master.recv_byte(1'h0, b);
    check("byte write", b, 8'hc3);
    master.stop();
    $display("test write control done");
    // A select byte without a start must be ignored
    master.send_byte(SEL_W, a);
    check("no start ack", {7'h0, a}, 8'h00);
    master.stop();
    idle();
    $display("test no start done");
    // Other strap levels move the address the slave answers to
    @(posedge sys_clk) pins <= 3'h2;
    master.start();
    master.send_byte({4'ha, 3'h2, 1'h0}, a);
    check("moved strap ack", {7'h0, a}, 8'h01);
    master.stop();
    idle();
    master.start();
    master.send_byte(SEL_W, a);
    check("old strap ack", {7'h0, a}, 8'h00);
    master.stop();
    idle();
    @(posedge sys_clk) pins <= STRAP;
    $display("test strap pins done");
    // Lock bit in the protection register; a locked array keeps its old byte
    master.start();
    master.send_byte(8'h6a, a);
    master.send_byte(8'h00, a);
    master.send_byte(8'h01, a);
    check("prot data ack", {7'h0, a}, 8'h01);
    master.stop();
    idle();
    master.start();
    master.send_byte(8'h6b, a);
    master.recv_byte(1'h0, b);
    check("prot read", b, 8'h01);
    master.stop();
    wr1(8'h15, 8'h5a);
    point(8'h15);
    master.recv_byte(1'h0, b);
    check("locked array", b, 8'hc3);
    master.stop();
    $display("test protection register done");
    master.start();
    master.send_byte(SEL_W, a);
    @(posedge sys_clk) arst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    check("reset oe", {7'h0, sda_oe}, 8'h00);
    check("reset standby", {7'h0, standby}, 8'h01);
    check("reset busy", {7'h0, busy}, 8'h00);
    @(posedge sys_clk) arst_n <= 1'h1;
    repeat (8) @(posedge sys_clk);
    master.stop();
    idle();
    $display("test mid-run reset done");
    results();
  end
endmodule // module_info_eeprom_tb_top
